// >>> logic/overtemp_cfg.svh
// Purpose: offsets, reset values and timing counts for the over-temperature timer block
// Assumes: 250 MHz core clock
// Notes:   included by the package; definitions only
`ifndef OVERTEMP_CFG_SVH
`define OVERTEMP_CFG_SVH

`define TIMER_VALUE_ADDR    8'h79
`define TIMER_LIMIT_ADDR    8'h7A
`define PULSES_SEL_ADDR     8'h7B

`define TIMER_VALUE_RESET   8'h00
`define TIMER_LIMIT_RESET   8'hFF
`define PULSES_SEL_RESET    8'h55
`define LIMIT_IMMEDIATE     8'h00
`define COUNT_MAX           8'hFF
`define READ_UNMAPPED       8'h00

`define ASSERT_FLAG_BIT     0
`define FAN_COUNT           4
`define FAN_SEL_W           2

`define STEP_TIME_NS        22760000
`define CLK_PERIOD_NS       4
`define STEP_CYCLES         (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define STEP_CNT_W          24
`define DIRECT_MIN_TIME_NS  45520000
`define DIRECT_MIN_STEPS    8'(`DIRECT_MIN_TIME_NS / `STEP_TIME_NS)

`endif

// >>> logic/overtemp_pkg.sv
// Purpose: state types of the over-temperature timer and tach counters
// Assumes: overtemp_cfg.svh supplies the widths
// Notes:   no constants of its own beyond the types
`include "overtemp_cfg.svh"

package overtemp_pkg;

  typedef enum logic [0:0] {
    TACH_IDLE,
    TACH_COUNT
  } tach_phase_t;

  typedef struct packed {
    logic [2:0]              sync;
    logic                    level;
    tach_phase_t             phase;
    logic [`FAN_SEL_W-1:0]   seen;
    logic                    measuring;
    logic                    done;
  } tach_state_t;

  typedef struct packed {
    logic [2:0]              sync;
    logic                    active;
    logic [`STEP_CNT_W-1:0]  prescale;
    logic [7:0]              count;
    logic                    flag;
    logic [7:0]              limit;
    logic [7:0]              pulses;
    logic [7:0]              rdata;
    logic                    exceed;
  } timer_state_t;

endpackage

// >>> logic/tach_pulse_counter.sv
// Purpose: counts tach pulses of one fan for one speed measurement
// Assumes: tach_pin is asynchronous; start is a one-cycle pulse on clk
// Notes:   start while counting restarts the measurement
`timescale 1ns/10ps
`default_nettype none
`include "overtemp_cfg.svh"

module tach_pulse_counter #(
  parameter int SEL_W = `FAN_SEL_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             tach_pin,
  input  wire logic             start,
  input  wire logic [SEL_W-1:0] pulse_select,
  output var  logic             measuring,
  output var  logic             done
);

  if (SEL_W != `FAN_SEL_W) begin : g_bad_sel
    $error("tach_pulse_counter: SEL_W must match the field width");
  end

  overtemp_pkg::tach_state_t s;
  overtemp_pkg::tach_state_t next_s;
  logic                      rise;

  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], tach_pin};
    next_s.done = 1'b0;
    // glitch filter: level moves only when the two later stages agree
    if (s.sync[1] == s.sync[2]) begin
      next_s.level = s.sync[2];
    end
    rise = next_s.level & ~s.level;
    case (s.phase)
      overtemp_pkg::TACH_IDLE: begin
        if (start) begin
          next_s.phase     = overtemp_pkg::TACH_COUNT;
          next_s.seen      = '0;
          next_s.measuring = 1'b1;
        end
      end
      overtemp_pkg::TACH_COUNT: begin
        if (start) begin
          next_s.seen = '0;
        end else if (rise) begin
          if (s.seen == pulse_select) begin
            next_s.phase     = overtemp_pkg::TACH_IDLE;
            next_s.measuring = 1'b0;
            next_s.done      = 1'b1;
          end else begin
            next_s.seen = s.seen + 1'b1;
          end
        end
      end
      default: begin
        next_s.phase = overtemp_pkg::TACH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s       <= '0;
      // pulled-up line idles high, so no false edge after reset
      s.sync  <= 3'b111;
      s.level <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign measuring = s.measuring;
  assign done      = s.done;

endmodule // tach_pulse_counter

`default_nettype wire

// >>> logic/overtemp_assert_timer_tach_pulses.sv
// Purpose: over-temperature assertion timer, its limit, and tach pulse selection
// Assumes: register port is driven by the serial slave engine on clk
// Notes:   interrupt status, mask and alert pin logic live outside
`timescale 1ns/10ps
`default_nettype none
`include "overtemp_cfg.svh"

module overtemp_assert_timer_tach_pulses #(
  parameter int unsigned STEP_CYCLES = `STEP_CYCLES,
  parameter int          FANS        = `FAN_COUNT
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    overtemp_signal_n,
  input  wire logic                    overtemp_enable,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_wdata,
  output var  logic [7:0]              reg_rdata,
  output var  logic                    assert_limit_exceeded_flag,
  input  wire logic [FANS-1:0]         tach_pin,
  input  wire logic [FANS-1:0]         tach_start,
  output var  logic [FANS-1:0]         tach_measuring,
  output var  logic [FANS-1:0]         tach_done
);

  if (STEP_CYCLES < 1 || STEP_CYCLES >= (1 << `STEP_CNT_W)) begin : g_bad_step
    $error("overtemp timer: STEP_CYCLES out of prescaler range");
  end
  if (FANS != `FAN_COUNT) begin : g_bad_fans
    $error("overtemp timer: pulse register holds exactly four fan fields");
  end

  localparam logic [`STEP_CNT_W-1:0] STEP_LAST = `STEP_CNT_W'(STEP_CYCLES - 1);

  overtemp_pkg::timer_state_t s;
  overtemp_pkg::timer_state_t next_s;
  logic                       rise;
  logic                       rd_value;
  logic [7:0]                 base;
  logic [7:0]                 stepped;

  // short assertions show only the flag; longer ones show the whole count
  function automatic logic [7:0] value_view(input logic [7:0] count, input logic flag);
    if (count >= `DIRECT_MIN_STEPS) begin
      value_view = count;
    end else begin
      value_view = {7'h00, flag};
    end
  endfunction

  always_comb begin
    next_s        = s;
    next_s.sync   = {s.sync[1:0], overtemp_signal_n};
    next_s.exceed = 1'b0;
    base          = s.count;
    stepped       = s.count;
    // active low pin, accepted once the two later stages agree
    if (s.sync[1] == s.sync[2]) begin
      next_s.active = ~s.sync[2] & overtemp_enable;
    end else begin
      next_s.active = s.active & overtemp_enable;
    end
    rise     = next_s.active & ~s.active;
    rd_value = reg_rd && (reg_addr == `TIMER_VALUE_ADDR);

    if (rd_value) begin
      next_s.flag  = 1'b0;
      next_s.count = `TIMER_VALUE_RESET;
      base         = `TIMER_VALUE_RESET;
    end
    // a new assertion in the read cycle still leaves the flag set
    if (rise) begin
      next_s.flag = 1'b1;
    end

    // prescaler keeps its phase between assertions so time adds up
    if (s.active) begin
      if (s.prescale == STEP_LAST) begin
        next_s.prescale = '0;
        if (base != `COUNT_MAX) begin
          stepped      = base + 8'h01;
          next_s.count = stepped;
          if (s.limit != `LIMIT_IMMEDIATE && base <= s.limit && stepped > s.limit) begin
            next_s.exceed = 1'b1;
          end
        end
      end else begin
        next_s.prescale = s.prescale + 1'b1;
      end
    end
    if (rise && s.limit == `LIMIT_IMMEDIATE) begin
      next_s.exceed = 1'b1;
    end

    if (reg_wr) begin
      if (reg_addr == `TIMER_LIMIT_ADDR) begin
        next_s.limit = reg_wdata;
      end else if (reg_addr == `PULSES_SEL_ADDR) begin
        next_s.pulses = reg_wdata;
      end
    end

    if (reg_rd) begin
      if (reg_addr == `TIMER_VALUE_ADDR) begin
        next_s.rdata = value_view(s.count, s.flag);
      end else if (reg_addr == `TIMER_LIMIT_ADDR) begin
        next_s.rdata = s.limit;
      end else if (reg_addr == `PULSES_SEL_ADDR) begin
        next_s.rdata = s.pulses;
      end else begin
        next_s.rdata = `READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s        <= '0;
      // idle pin is high; an all-zero stage would fake an assertion
      s.sync   <= 3'b111;
      s.count  <= `TIMER_VALUE_RESET;
      s.limit  <= `TIMER_LIMIT_RESET;
      s.pulses <= `PULSES_SEL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata                  = s.rdata;
  assign assert_limit_exceeded_flag = s.exceed;

  // one counter per fan; fan a uses the lowest field
  for (genvar i = 0; i < FANS; i++) begin : g_fan
    tach_pulse_counter #(
      .SEL_W        (`FAN_SEL_W)
    ) u_counter (
      .clk          (clk),
      .srst         (srst),
      .tach_pin     (tach_pin[i]),
      .start        (tach_start[i]),
      .pulse_select (s.pulses[i*`FAN_SEL_W +: `FAN_SEL_W]),
      .measuring    (tach_measuring[i]),
      .done         (tach_done[i])
    );
  end

endmodule // overtemp_assert_timer_tach_pulses

`default_nettype wire

// >>> logic/unused_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> bench/overtemp_fan_model.sv
// Purpose: hot-pin source and four tach fans
// Assumes: bench sets the hot and spin levels
// Notes: both pins pulled up, so idle reads high
`timescale 1ns/10ps
`default_nettype none
module overtemp_fan_model (
  input  wire logic       clk,
  input  wire logic       hot,
  input  wire logic [3:0] spin,
  output var  logic       overtemp_signal_n,
  output var  logic [3:0] tach_pin
);
  logic [3:0] div = 4'h0;
  always @(posedge clk) div <= div + 4'h1;
  always_comb overtemp_signal_n = ~hot;
  // a stopped fan leaves its line at the pull-up level
  always_comb tach_pin = (spin & {4{div[3]}}) | ~spin;
endmodule // overtemp_fan_model
`default_nettype wire

// >>> bench/overtemp_assert_timer_tach_pulses_assertions.sv
// Purpose: port checks of the timer block
// Assumes: one clock, srst sync high
// Notes: bound at the foot
`timescale 1ns/10ps
`default_nettype none
module overtemp_timer_checker #(
  parameter int unsigned STEP_CYCLES = 8,
  parameter int          FANS        = 4
) (
  input wire logic            clk,
  input wire logic            srst,
  input wire logic            overtemp_signal_n,
  input wire logic            overtemp_enable,
  input wire logic [7:0]      reg_addr,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic            assert_limit_exceeded_flag,
  input wire logic [FANS-1:0] tach_start,
  input wire logic [FANS-1:0] tach_measuring,
  input wire logic [FANS-1:0] tach_done
);
  logic       hit;
  logic [7:0] lim;
  assign hit = assert_limit_exceeded_flag;
  // own copy of the limit, so read-back is not judged by itself
  always_ff @(posedge clk) begin
    if (srst) lim <= 8'hFF;
    else if (reg_wr && reg_addr == 8'h7A) lim <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_hot_edge;
    overtemp_enable && lim == 8'h00 && $fell(overtemp_signal_n);
  endsequence
  a_zero_fires: assert property (s_hot_edge |-> ##[2:7] hit)
    else $error("no pulse at zero limit");
  a_ff_silent: assert property (lim == 8'hFF && $past(lim) == 8'hFF |-> !hit)
    else $error("pulse with limit FF");
  a_hit_pulse: assert property (hit |=> !hit)
    else $error("limit pulse too long");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h79 || reg_addr > 8'h7B)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_limit_back: assert property (reg_rd && reg_addr == 8'h7A |=> reg_rdata == $past(lim))
    else $error("limit read-back wrong");
  a_start_runs: assert property (tach_start[0] |=> tach_measuring[0])
    else $error("start did not run");
  a_done_ends: assert property (tach_done[0] |-> !tach_measuring[0] ##1 !tach_done[0])
    else $error("done not a closing pulse");
endmodule // overtemp_timer_checker
bind overtemp_assert_timer_tach_pulses overtemp_timer_checker #(
  .STEP_CYCLES(STEP_CYCLES),
  .FANS(FANS)
) i_overtemp_timer_checker (.*);
`default_nettype wire

// >>> bench/overtemp_assert_timer_tach_pulses_tb.sv
// Purpose: scenario bench of the timer block
// Assumes: step shortened to 8 cycles
// Notes: inputs move on falling edges
`timescale 1ns/10ps
`default_nettype none
module overtemp_assert_timer_tach_pulses_tb;
  logic       clk = 1'b0, srst = 1'b1, hot = 1'b0, en = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       ot_n, hit;
  logic [3:0] spin = 4'h0, start = 4'h0, tpin, meas, done;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  int         err_total = 0, cmp_count = 0, hits = 0, cyc = 0;
  initial forever #2 clk = ~clk;
  overtemp_fan_model i_overtemp_fan_model (.clk(clk), .hot(hot), .spin(spin),
    .overtemp_signal_n(ot_n), .tach_pin(tpin));
  overtemp_assert_timer_tach_pulses #(.STEP_CYCLES(8)) i_overtemp_assert_timer_tach_pulses (
    .clk(clk), .srst(srst), .overtemp_signal_n(ot_n), .overtemp_enable(en), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .assert_limit_exceeded_flag(hit), .tach_pin(tpin), .tach_start(start),
    .tach_measuring(meas), .tach_done(done));
  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hit === 1'b1) hits <= hits + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(what, exp, rdata);
  endtask
  // tail of 12 cycles lets the pin synchroniser release
  task automatic heat(input int n);
    @(negedge clk);
    hot = 1'b1;
    repeat (n) @(negedge clk);
    hot = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  task automatic t_regs;
    rchk("reset value", 8'h79, 8'h00);
    rchk("reset limit", 8'h7A, 8'hFF);
    rchk("reset pulses", 8'h7B, 8'h55);
    acc(1'b1, 8'h79, 8'hA5);
    acc(1'b1, 8'h7C, 8'h3C);
    rchk("value ro", 8'h79, 8'h00);
    rchk("unmapped", 8'h7C, 8'h00);
    acc(1'b1, 8'h7A, 8'h5A);
    rchk("limit rw", 8'h7A, 8'h5A);
  endtask
  // durations rely on the prescaler phase: 0 at the first enabled heat, 3 after it
  task automatic t_timer;
    heat(40);
    rchk("disabled", 8'h79, 8'h00);
    en = 1'b1;
    heat(3);
    rchk("short", 8'h79, 8'h01);
    rchk("cleared", 8'h79, 8'h00);
    heat(13);
    heat(12);
    rchk("summed", 8'h79, 8'h03);
    rchk("restart", 8'h79, 8'h00);
  endtask
  task automatic t_limit;
    int n0;
    n0 = hits;
    acc(1'b1, 8'h7A, 8'h02);
    heat(40);
    chk("crossing", 8'h01, 8'(hits - n0));
    acc(1'b0, 8'h79, 8'h00);
    acc(1'b1, 8'h7A, 8'h00);
    heat(4);
    chk("zero limit", 8'h02, 8'(hits - n0));
    acc(1'b1, 8'h7A, 8'hFF);
    heat(40);
    chk("ff limit", 8'h02, 8'(hits - n0));
  endtask
  task automatic t_tach;
    int   edges;
    logic prev;
    spin = 4'hF;
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 8'h7B, {4{2'(s)}});
      rchk("pulses rw", 8'h7B, {4{2'(s)}});
      @(posedge tpin[0]);
      repeat (6) @(negedge clk);
      start = 4'hF;
      @(negedge clk);
      start = 4'h0;
      edges = 0;
      prev = tpin[0];
      for (int c = 0; c < 100 && done[0] !== 1'b1; c++) begin
        @(negedge clk);
        if (tpin[0] && !prev) edges++;
        prev = tpin[0];
      end
      chk("tach edges", 8'(s + 1), 8'(edges));
      chk("tach end", 8'h0F, {meas, done});
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_regs();
    t_timer();
    t_limit();
    t_tach();
    final_report();
  end
endmodule // overtemp_assert_timer_tach_pulses_tb
`default_nettype wire
